// *** tpc_pkg.sv ***
// Constants, register map and field layout of the 16-bit interval/pulse/capture timer
package tpc_pkg;

   // Byte register addresses on the memory-manipulation port
   localparam logic [15:0] ADDR_PORT_LATCH   = 16'hFF03;
   localparam logic [15:0] ADDR_CNT_LO       = 16'hFF10;
   localparam logic [15:0] ADDR_CNT_HI       = 16'hFF11;
   localparam logic [15:0] ADDR_REG_A_LO     = 16'hFF12;
   localparam logic [15:0] ADDR_REG_A_HI     = 16'hFF13;
   localparam logic [15:0] ADDR_REG_B_LO     = 16'hFF14;
   localparam logic [15:0] ADDR_REG_B_HI     = 16'hFF15;
   localparam logic [15:0] ADDR_PORT_DIR     = 16'hFF23;
   localparam logic [15:0] ADDR_MODE_CTRL    = 16'hFF60;
   localparam logic [15:0] ADDR_PRESCALER    = 16'hFF61;
   localparam logic [15:0] ADDR_CMP_CAP_CTRL = 16'hFF62;
   localparam logic [15:0] ADDR_OUT_CTRL     = 16'hFF63;

   // Reset values and word constants
   localparam logic [7:0]  PORT_DIR_RST      = 8'hFF;
   localparam logic [7:0]  BYTE_RST          = 8'h00;
   localparam logic [15:0] WORD_RST          = 16'h0000;
   localparam logic [15:0] WORD_MAX          = 16'hFFFF;
   localparam logic [15:0] WORD_ONE          = 16'h0001;

   // Timer mode control fields
   localparam int MODE_OVF_BIT   = 0;
   localparam int MODE_LSB       = 2;
   localparam int MODE_MSB       = 3;

   // Prescaler mode fields
   localparam int CLK_SEL_LSB    = 0;
   localparam int CLK_SEL_MSB    = 1;
   localparam int PRIM_EDGE_LSB  = 4;
   localparam int PRIM_EDGE_MSB  = 5;
   localparam int SEC_EDGE_LSB   = 6;
   localparam int SEC_EDGE_MSB   = 7;

   // Compare/capture control bits
   localparam int CC_A_CAPTURE   = 0;
   localparam int CC_A_TRIG_SEL  = 1;
   localparam int CC_B_CAPTURE   = 2;

   // Timer output control bits
   localparam int OUT_ENABLE     = 0;
   localparam int OUT_INV_A      = 1;
   localparam int OUT_LVL_RESET  = 2;
   localparam int OUT_LVL_SET    = 3;
   localparam int OUT_INV_B      = 4;
   localparam logic [7:0] OUT_CTRL_RD_MASK = 8'h13;

   // Shared pin positions within the port
   localparam int SHARED_PIN     = 1;
   localparam int SECONDARY_PIN  = 0;

   // Count clock dividers of the 125 MHz system clock
   localparam int CLK_DIV_BASE   = 8;
   localparam int CLK_DIV_HALF   = 16;
   localparam int CLK_DIV_FAST   = 4;

   typedef enum logic [1:0] {
      TPC_MODE_STOP    = 2'b00,
      TPC_MODE_RESTART = 2'b01,
      TPC_MODE_FREE    = 2'b10,
      TPC_MODE_CLEAR_A = 2'b11
   } tpc_mode_t;

   typedef enum logic [1:0] {
      TPC_EDGE_FALL = 2'b00,
      TPC_EDGE_RISE = 2'b01,
      TPC_EDGE_NONE = 2'b10,
      TPC_EDGE_BOTH = 2'b11
   } tpc_edge_t;

   typedef enum logic [1:0] {
      TPC_CLK_BASE = 2'b00,
      TPC_CLK_HALF = 2'b01,
      TPC_CLK_FAST = 2'b10,
      TPC_CLK_EXT  = 2'b11
   } tpc_clk_t;

endpackage

// *** tpc_edge_if.sv ***
// Interface between the timer core and one input edge filter
`timescale 1ns/10ps
interface tpc_edge_if;
   logic             pin;
   logic             sample_en;
   tpc_pkg::tpc_edge_t edge_sel;
   logic             valid_edge;
   logic             inv_edge;

   modport filter (input pin, input sample_en, input edge_sel, output valid_edge, output inv_edge);
   modport core   (output pin, output sample_en, output edge_sel, input valid_edge, input inv_edge);
endinterface

// *** tpc_edge_filter.sv ***
// Synchroniser, two-sample noise filter and edge selector for one timer input
`timescale 1ns/10ps
module tpc_edge_filter (
   input  wire logic  clk_i,
   input  wire logic  reset_i,
   tpc_edge_if.filter bus
);
   logic sync1_q;
   logic sync2_q;
   logic samp_q;
   logic stable_q;
   logic rise_q;
   logic fall_q;
   logic settle;

   // Level accepted only after two equal successive samples
   assign settle = bus.sample_en && (samp_q == sync2_q) && (stable_q != sync2_q);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync1_q  <= 1'b0;
         sync2_q  <= 1'b0;
         samp_q   <= 1'b0;
         stable_q <= 1'b0;
         rise_q   <= 1'b0;
         fall_q   <= 1'b0;
      end else begin
         sync1_q <= bus.pin;
         sync2_q <= sync1_q;
         if (bus.sample_en) begin
            samp_q <= sync2_q;
         end
         if (settle) begin
            stable_q <= sync2_q;
         end
         rise_q <= settle && sync2_q;
         fall_q <= settle && !sync2_q;
      end
   end

   // Prohibited setting yields no edge; both edges give no inverse edge
   assign bus.valid_edge = (bus.edge_sel == tpc_pkg::TPC_EDGE_RISE) ? rise_q :
                           (bus.edge_sel == tpc_pkg::TPC_EDGE_FALL) ? fall_q :
                           (bus.edge_sel == tpc_pkg::TPC_EDGE_BOTH) ? (rise_q | fall_q) : 1'b0;
   assign bus.inv_edge   = (bus.edge_sel == tpc_pkg::TPC_EDGE_RISE) ? fall_q :
                           (bus.edge_sel == tpc_pkg::TPC_EDGE_FALL) ? rise_q : 1'b0;
endmodule // tpc_edge_filter

// *** tpc_timer.sv ***
// 16-bit interval timer, pulse generator and pulse-width capture unit with port direction register
// Notes on behaviour
// (R1) Direction bit 0 output, 1 input
// (R2) Reset sets direction register to all ones
// (R3) Software sets shared pin output, latch zero
// (R4) Direction register takes bit and byte writes
// (R5) Interval mode: match A clears, raises irq
// (R6) Prescaler low bits choose count clock
// (R7) Pulse generator drives shared pin waveform
// (R8) Software keeps 0 < B < A <= max
// (R9) Period A+1, duty (B+1)/(A+1)
// (R10) Primary edge captures counter into B
// (R11) Prescaler bits 4,5 select primary edge
// (R12) Secondary edge captures into A, irq
// (R13) Edges: rising, falling or both
// (R14) Two equal samples per count clock
// (R15) Opposite primary edge captures into A
// (R16) Two-register mode uses single edge
// (R17) Both edges selected: A never captures
// (R18) Edge codes: 00 fall, 01 rise, 11 both
// (R19) Trigger select: secondary or inverse primary
// (R20) Invert bit toggles output on match
// (R21) Pulse mode toggles on both matches
// (R22) Capture flag set with captured value
`timescale 1ns/10ps
module tpc_timer #(
   parameter int DIV_BASE = tpc_pkg::CLK_DIV_BASE,
   parameter int DIV_HALF = tpc_pkg::CLK_DIV_HALF,
   parameter int DIV_FAST = tpc_pkg::CLK_DIV_FAST
) (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic [15:0] cpu_addr_i,
   input  wire logic        cpu_wr_i,
   input  wire logic        cpu_bit_wr_i,
   input  wire logic [2:0]  cpu_bit_idx_i,
   input  wire logic [7:0]  cpu_wdata_i,
   output logic      [7:0]  cpu_rdata_o,
   input  wire logic        primary_timer_in_i,
   input  wire logic        secondary_timer_in_i,
   output logic      [7:0]  port_pin_o,
   output logic      [7:0]  port_pin_oe_o,
   output logic      [7:0]  port_direction_o,
   output logic             irq_match_a_o,
   output logic             irq_capture_b_o
);
   logic [7:0]  port_direction_reg_q;
   logic [7:0]  port_latch_q;
   logic [7:0]  timer_mode_ctrl_q;
   logic [7:0]  prescaler_mode_reg_q;
   logic [7:0]  cmp_cap_ctrl_q;
   logic [7:0]  timer_out_ctrl_q;
   logic [15:0] main_counter_q;
   logic [15:0] cmp_cap_reg_a_q;
   logic [15:0] cmp_cap_reg_b_q;
   logic [15:0] div_cnt_q;
   logic        out_ff_q;
   logic        irq_a_q;
   logic        irq_b_q;
   logic [7:0]  rdata_q;

   tpc_edge_if eif[2] ();

   // Per-input filters: index 0 primary, 1 secondary
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_in
         tpc_edge_filter u_filt (
            .clk_i   (clk_i),
            .reset_i (reset_i),
            .bus     (eif[g])
         );
      end
   endgenerate

   tpc_pkg::tpc_mode_t mode;
   tpc_pkg::tpc_clk_t  clk_sel;
   tpc_pkg::tpc_edge_t prim_edge_sel;
   logic [15:0] div_limit;
   logic        div_tick;
   logic        count_tick;
   logic        running;
   logic        ext_clk;
   logic        prim_valid;
   logic        prim_inv;
   logic        sec_valid;
   logic        hit_a;
   logic        hit_b;
   logic        match_a;
   logic        match_b;
   logic        clear_a;
   logic        cap_a;
   logic        cap_b;
   logic        wrap;
   logic        timer_out;

   assign mode          = tpc_pkg::tpc_mode_t'(timer_mode_ctrl_q[tpc_pkg::MODE_MSB:tpc_pkg::MODE_LSB]);
   assign clk_sel       = tpc_pkg::tpc_clk_t'(prescaler_mode_reg_q[tpc_pkg::CLK_SEL_MSB:tpc_pkg::CLK_SEL_LSB]); // R6
   assign prim_edge_sel = tpc_pkg::tpc_edge_t'(
                             prescaler_mode_reg_q[tpc_pkg::PRIM_EDGE_MSB:tpc_pkg::PRIM_EDGE_LSB]); // R11
   assign running       = (mode != tpc_pkg::TPC_MODE_STOP) && (mode != tpc_pkg::TPC_MODE_RESTART);
   assign ext_clk       = (clk_sel == tpc_pkg::TPC_CLK_EXT);

   // External count clock still needs a sample rate for its own filter
   assign div_limit = (clk_sel == tpc_pkg::TPC_CLK_BASE) ? 16'(DIV_BASE - 1) :
                      (clk_sel == tpc_pkg::TPC_CLK_HALF) ? 16'(DIV_HALF - 1) : 16'(DIV_FAST - 1); // R6
   assign div_tick  = (div_cnt_q >= div_limit);

   assign eif[0].pin       = primary_timer_in_i;
   assign eif[0].sample_en = div_tick; // R14
   assign eif[0].edge_sel  = prim_edge_sel; // R13 R18
   assign eif[1].pin       = secondary_timer_in_i;
   assign eif[1].sample_en = div_tick; // R14
   assign eif[1].edge_sel  = tpc_pkg::tpc_edge_t'(
                                prescaler_mode_reg_q[tpc_pkg::SEC_EDGE_MSB:tpc_pkg::SEC_EDGE_LSB]); // R12 R13 R18

   assign prim_valid = eif[0].valid_edge;
   assign prim_inv   = eif[0].inv_edge; // R16 R17
   assign sec_valid  = eif[1].valid_edge;

   assign count_tick = running && (ext_clk ? prim_valid : div_tick); // R6

   // Compare matches only while the register is in compare role
   assign hit_a   = count_tick && (main_counter_q == cmp_cap_reg_a_q);
   assign hit_b   = count_tick && (main_counter_q == cmp_cap_reg_b_q);
   assign match_a = hit_a && !cmp_cap_ctrl_q[tpc_pkg::CC_A_CAPTURE];
   assign match_b = hit_b && !cmp_cap_ctrl_q[tpc_pkg::CC_B_CAPTURE];
   assign clear_a = match_a && (mode == tpc_pkg::TPC_MODE_CLEAR_A); // R5 R9
   assign wrap    = count_tick && !clear_a && (main_counter_q == tpc_pkg::WORD_MAX);

   // Captures never use the input that is already the count clock
   assign cap_b = running && !ext_clk && cmp_cap_ctrl_q[tpc_pkg::CC_B_CAPTURE] && prim_valid; // R10
   assign cap_a = running && !ext_clk && cmp_cap_ctrl_q[tpc_pkg::CC_A_CAPTURE] &&
                  (cmp_cap_ctrl_q[tpc_pkg::CC_A_TRIG_SEL] ? prim_inv : sec_valid); // R12 R15 R19

   // CPU write decode
   logic       wr_dir;
   logic       wr_latch;
   logic       wr_mode;
   logic       wr_pre;
   logic       wr_cc;
   logic       wr_out;
   logic       bit_val;
   logic [7:0] bit_mask;

   assign wr_dir   = cpu_wr_i && (cpu_addr_i == tpc_pkg::ADDR_PORT_DIR);
   assign wr_latch = cpu_wr_i && (cpu_addr_i == tpc_pkg::ADDR_PORT_LATCH);
   assign wr_mode  = cpu_wr_i && (cpu_addr_i == tpc_pkg::ADDR_MODE_CTRL);
   assign wr_pre   = cpu_wr_i && !cpu_bit_wr_i && (cpu_addr_i == tpc_pkg::ADDR_PRESCALER);
   assign wr_cc    = cpu_wr_i && (cpu_addr_i == tpc_pkg::ADDR_CMP_CAP_CTRL);
   assign wr_out   = cpu_wr_i && (cpu_addr_i == tpc_pkg::ADDR_OUT_CTRL);
   assign bit_val  = cpu_wdata_i[0];
   assign bit_mask = 8'h01 << cpu_bit_idx_i;

   // Bit write touches one bit only, byte write replaces all
   function automatic logic [7:0] merge(input logic [7:0] old);
      merge = cpu_bit_wr_i ? ((old & ~bit_mask) | (bit_val ? bit_mask : 8'h00)) : cpu_wdata_i;
   endfunction

   logic [7:0] out_ctrl_new;
   assign out_ctrl_new = merge(timer_out_ctrl_q);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         port_direction_reg_q <= tpc_pkg::PORT_DIR_RST; // R2
         port_latch_q         <= tpc_pkg::BYTE_RST;
         timer_mode_ctrl_q    <= tpc_pkg::BYTE_RST;
         prescaler_mode_reg_q <= tpc_pkg::BYTE_RST;
         cmp_cap_ctrl_q       <= tpc_pkg::BYTE_RST;
         timer_out_ctrl_q     <= tpc_pkg::BYTE_RST;
      end else begin
         if (wr_dir) begin
            port_direction_reg_q <= merge(port_direction_reg_q); // R4
         end
         if (wr_latch) begin
            port_latch_q <= merge(port_latch_q);
         end
         if (wr_mode) begin
            timer_mode_ctrl_q <= merge(timer_mode_ctrl_q);
         end
         if (wrap) begin
            timer_mode_ctrl_q[tpc_pkg::MODE_OVF_BIT] <= 1'b1;
         end
         if (wr_pre) begin
            prescaler_mode_reg_q <= cpu_wdata_i;
         end
         if (wr_cc) begin
            cmp_cap_ctrl_q <= merge(cmp_cap_ctrl_q);
         end
         if (wr_out) begin
            timer_out_ctrl_q <= out_ctrl_new & tpc_pkg::OUT_CTRL_RD_MASK;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_cnt_q      <= tpc_pkg::WORD_RST;
         main_counter_q <= tpc_pkg::WORD_RST;
      end else begin
         div_cnt_q <= div_tick ? tpc_pkg::WORD_RST : div_cnt_q + tpc_pkg::WORD_ONE;
         if (!running) begin
            main_counter_q <= tpc_pkg::WORD_RST;
         end else if (clear_a) begin
            main_counter_q <= tpc_pkg::WORD_RST; // R5
         end else if (count_tick) begin
            main_counter_q <= main_counter_q + tpc_pkg::WORD_ONE;
         end
      end
   end

   // Capture wins over a CPU write in the same cycle
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cmp_cap_reg_a_q <= tpc_pkg::WORD_RST;
         cmp_cap_reg_b_q <= tpc_pkg::WORD_RST;
         irq_a_q         <= 1'b0;
         irq_b_q         <= 1'b0;
      end else begin
         if (cap_a) begin
            cmp_cap_reg_a_q <= main_counter_q; // R12 R15
         end else if (cpu_wr_i && !cpu_bit_wr_i && cpu_addr_i == tpc_pkg::ADDR_REG_A_LO) begin
            cmp_cap_reg_a_q[7:0] <= cpu_wdata_i;
         end else if (cpu_wr_i && !cpu_bit_wr_i && cpu_addr_i == tpc_pkg::ADDR_REG_A_HI) begin
            cmp_cap_reg_a_q[15:8] <= cpu_wdata_i;
         end
         if (cap_b) begin
            cmp_cap_reg_b_q <= main_counter_q; // R10
         end else if (cpu_wr_i && !cpu_bit_wr_i && cpu_addr_i == tpc_pkg::ADDR_REG_B_LO) begin
            cmp_cap_reg_b_q[7:0] <= cpu_wdata_i;
         end else if (cpu_wr_i && !cpu_bit_wr_i && cpu_addr_i == tpc_pkg::ADDR_REG_B_HI) begin
            cmp_cap_reg_b_q[15:8] <= cpu_wdata_i;
         end
         irq_a_q <= match_a || cap_a; // R5 R12 R22
         irq_b_q <= match_b || cap_b; // R10 R22
      end
   end

   // Output flip-flop: level set/reset writes, then match toggles
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         out_ff_q <= 1'b0;
      end else if (wr_out && out_ctrl_new[tpc_pkg::OUT_LVL_SET] && !out_ctrl_new[tpc_pkg::OUT_LVL_RESET]) begin
         out_ff_q <= 1'b1;
      end else if (wr_out && out_ctrl_new[tpc_pkg::OUT_LVL_RESET] && !out_ctrl_new[tpc_pkg::OUT_LVL_SET]) begin
         out_ff_q <= 1'b0;
      end else begin
         out_ff_q <= out_ff_q ^ ((match_a && timer_out_ctrl_q[tpc_pkg::OUT_INV_A]) ^
                                 (match_b && timer_out_ctrl_q[tpc_pkg::OUT_INV_B])); // R20 R21 R9
      end
   end

   assign timer_out = timer_out_ctrl_q[tpc_pkg::OUT_ENABLE] && out_ff_q; // R7

   // Timer output is ORed onto the shared latch bit, so that latch must stay 0
   always_comb begin
      port_pin_o             = port_latch_q;
      port_pin_o[tpc_pkg::SHARED_PIN] = port_latch_q[tpc_pkg::SHARED_PIN] | timer_out; // R3 R7
   end
   assign port_pin_oe_o    = ~port_direction_reg_q; // R1
   assign port_direction_o = port_direction_reg_q;

   // Registered read data, one cycle after the address
   logic [7:0] rdata_d;
   always_comb begin
      case (cpu_addr_i)
         tpc_pkg::ADDR_PORT_DIR:     rdata_d = port_direction_reg_q;
         tpc_pkg::ADDR_PORT_LATCH:   rdata_d = port_latch_q;
         tpc_pkg::ADDR_MODE_CTRL:    rdata_d = timer_mode_ctrl_q;
         tpc_pkg::ADDR_PRESCALER:    rdata_d = prescaler_mode_reg_q;
         tpc_pkg::ADDR_CMP_CAP_CTRL: rdata_d = cmp_cap_ctrl_q;
         tpc_pkg::ADDR_OUT_CTRL:     rdata_d = timer_out_ctrl_q & tpc_pkg::OUT_CTRL_RD_MASK;
         tpc_pkg::ADDR_CNT_LO:       rdata_d = main_counter_q[7:0];
         tpc_pkg::ADDR_CNT_HI:       rdata_d = main_counter_q[15:8];
         tpc_pkg::ADDR_REG_A_LO:     rdata_d = cmp_cap_reg_a_q[7:0];
         tpc_pkg::ADDR_REG_A_HI:     rdata_d = cmp_cap_reg_a_q[15:8];
         tpc_pkg::ADDR_REG_B_LO:     rdata_d = cmp_cap_reg_b_q[7:0];
         tpc_pkg::ADDR_REG_B_HI:     rdata_d = cmp_cap_reg_b_q[15:8];
         default:                    rdata_d = tpc_pkg::BYTE_RST;
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_q <= tpc_pkg::BYTE_RST;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign cpu_rdata_o     = rdata_q;
   assign irq_match_a_o   = irq_a_q;
   assign irq_capture_b_o = irq_b_q;
endmodule // tpc_timer

// *** tpc_timer_assertions.sv ***
// Port-level checker of the timer block
`timescale 1ns/10ps
module tpc_timer_assertions (
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic [15:0] cpu_addr_i,
   input wire logic        cpu_wr_i,
   input wire logic        cpu_bit_wr_i,
   input wire logic [2:0]  cpu_bit_idx_i,
   input wire logic [7:0]  cpu_wdata_i,
   input wire logic [7:0]  cpu_rdata_o,
   input wire logic        primary_timer_in_i,
   input wire logic        secondary_timer_in_i,
   input wire logic [7:0]  port_pin_o,
   input wire logic [7:0]  port_pin_oe_o,
   input wire logic [7:0]  port_direction_o,
   input wire logic        irq_match_a_o,
   input wire logic        irq_capture_b_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic       dir_sel;
   logic [7:0] bit_exp;
   assign dir_sel = (cpu_addr_i == tpc_pkg::ADDR_PORT_DIR);
   // Only the indexed bit may move on a bit write
   assign bit_exp = (port_direction_o & ~(8'h01 << cpu_bit_idx_i)) | ({7'h00, cpu_wdata_i[0]} << cpu_bit_idx_i);
   sequence s_byte_wr;
      cpu_wr_i && !cpu_bit_wr_i && dir_sel;
   endsequence
   sequence s_bit_wr;
      cpu_wr_i && cpu_bit_wr_i && dir_sel;
   endsequence
   property p_dir_reset;
      $fell(reset_i) |-> port_direction_o == tpc_pkg::PORT_DIR_RST;
   endproperty
   property p_oe_dir;
      port_pin_oe_o == ~port_direction_o;
   endproperty
   property p_byte_wr;
      s_byte_wr |=> port_direction_o == $past(cpu_wdata_i);
   endproperty
   property p_bit_wr;
      s_bit_wr |=> port_direction_o == $past(bit_exp);
   endproperty
   property p_dir_hold;
      !(cpu_wr_i && dir_sel) |=> $stable(port_direction_o);
   endproperty
   property p_rd_dir;
      dir_sel && !cpu_wr_i |=> cpu_rdata_o == $past(port_direction_o);
   endproperty
   property p_irq_a_pulse;
      $rose(irq_match_a_o) |=> !irq_match_a_o;
   endproperty
   property p_irq_b_pulse;
      $rose(irq_capture_b_o) |=> !irq_capture_b_o;
   endproperty
   a_dir_reset: assert property (p_dir_reset) else $error("direction not all inputs after reset");
   a_oe_dir: assert property (p_oe_dir) else $error("output enable not inverse of direction");
   a_byte_wr: assert property (p_byte_wr) else $error("direction byte write lost");
   a_bit_wr: assert property (p_bit_wr) else $error("direction bit write wrong");
   a_dir_hold: assert property (p_dir_hold) else $error("direction changed without write");
   a_rd_dir: assert property (p_rd_dir) else $error("direction readback wrong");
   a_irq_a_pulse: assert property (p_irq_a_pulse) else $error("match A request longer than one cycle");
   a_irq_b_pulse: assert property (p_irq_b_pulse) else $error("capture B request longer than one cycle");
endmodule // tpc_timer_assertions

bind tpc_timer tpc_timer_assertions tpc_timer_assertions_inst (.clk_i, .reset_i, .cpu_addr_i, .cpu_wr_i,
   .cpu_bit_wr_i, .cpu_bit_idx_i, .cpu_wdata_i, .cpu_rdata_o, .primary_timer_in_i, .secondary_timer_in_i,
   .port_pin_o, .port_pin_oe_o, .port_direction_o, .irq_match_a_o, .irq_capture_b_o);

// *** tpc_pulse_src.sv ***
// Far-side pulse source on the two timer inputs
`timescale 1ns/10ps
module tpc_pulse_src (
   input  wire logic clk_i,
   output logic      prim_o,
   output logic      sec_o
);
   initial begin
      prim_o = 1'b0;
      sec_o  = 1'b0;
   end
   // Called at a falling edge; lines idle low between pulses
   task automatic pulse(input bit sec, input int hi, input int lo);
      if (sec) sec_o = 1'b1;
      else prim_o = 1'b1;
      repeat (hi) @(negedge clk_i);
      if (sec) sec_o = 1'b0;
      else prim_o = 1'b0;
      repeat (lo) @(negedge clk_i);
   endtask
endmodule // tpc_pulse_src

// *** test_timer16_interval_ppg_capture.sv ***
// Self-checking bench of the timer block
`timescale 1ns/10ps
module test_timer16_interval_ppg_capture;
   // Short dividers keep the run brief; interval and pulse checks scale with them, capture counts assume DB = 2
   localparam int DB = 2;
   localparam int DH = 4;
   localparam int DF = 3;
   logic        clk_i   = 1'b0;
   logic        reset_i = 1'b1;
   logic [15:0] addr    = 16'h0000;
   logic        wr      = 1'b0;
   logic        bwr     = 1'b0;
   logic [2:0]  bidx    = 3'h0;
   logic [7:0]  wdata   = 8'h00;
   logic [7:0]  rdata, pin, oe, dir, d;
   logic        prim, sec, irq_a, irq_b;
   int          err_count = 0;
   int          n_compared = 0;
   int          n, hi, lo;
   always #4 clk_i = ~clk_i;
   tpc_timer #(.DIV_BASE(DB), .DIV_HALF(DH), .DIV_FAST(DF)) tpc_timer_inst (.clk_i(clk_i), .reset_i(reset_i),
      .cpu_addr_i(addr), .cpu_wr_i(wr), .cpu_bit_wr_i(bwr), .cpu_bit_idx_i(bidx), .cpu_wdata_i(wdata),
      .cpu_rdata_o(rdata), .primary_timer_in_i(prim), .secondary_timer_in_i(sec), .port_pin_o(pin),
      .port_pin_oe_o(oe), .port_direction_o(dir), .irq_match_a_o(irq_a), .irq_capture_b_o(irq_b));
   tpc_pulse_src tpc_pulse_src_inst (.clk_i(clk_i), .prim_o(prim), .sec_o(sec));
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_b(input logic [15:0] a, input logic [7:0] v);
      @(negedge clk_i);
      addr  = a;
      wdata = v;
      bwr   = 1'b0;
      wr    = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
   endtask
   task automatic wr_bit(input logic [2:0] i, input logic v);
      @(negedge clk_i);
      addr  = tpc_pkg::ADDR_PORT_DIR;
      wdata = {7'h00, v};
      bidx  = i;
      bwr   = 1'b1;
      wr    = 1'b1;
      @(negedge clk_i);
      wr  = 1'b0;
      bwr = 1'b0;
   endtask
   task automatic rd_b(input logic [15:0] a, output logic [7:0] v);
      @(negedge clk_i);
      addr = a;
      @(negedge clk_i);
      v = rdata;
   endtask
   task automatic rd_w(input logic [15:0] a, output logic [15:0] v);
      rd_b(a, v[7:0]);
      rd_b(a + 16'h0001, v[15:8]);
   endtask
   // Kind 0 match A request, 1 capture B request, 2 shared pin output
   task automatic wait_sig(input int k, input logic v, output int c);
      c = 0;
      do begin
         @(posedge clk_i);
         #1;
         c++;
         if (c > 3000) begin
            err_count++;
            end_sim();
         end
      end while ((k == 0 ? irq_a : (k == 1 ? irq_b : pin[1])) !== v);
   endtask
   task automatic cap_setup(input logic [7:0] prm, input logic [7:0] crc);
      wr_b(tpc_pkg::ADDR_MODE_CTRL, 8'h00);
      wr_b(tpc_pkg::ADDR_PRESCALER, prm);
      wr_b(tpc_pkg::ADDR_CMP_CAP_CTRL, crc);
      wr_b(tpc_pkg::ADDR_MODE_CTRL, 8'h08);
   endtask
   // Two pulses 40 high, 60 low; difference of two captured counts
   task automatic cap_pair(input logic [7:0] prm, crc, input bit src, o1, o2, input int exp);
      logic [15:0] v1, v2;
      int          c;
      cap_setup(prm, crc);
      fork
         begin
            @(negedge clk_i);
            tpc_pulse_src_inst.pulse(src, 40, 60);
            tpc_pulse_src_inst.pulse(src, 40, 60);
         end
         begin
            wait_sig(o1, 1'b1, c);
            rd_w(o1 ? tpc_pkg::ADDR_REG_B_LO : tpc_pkg::ADDR_REG_A_LO, v1);
            wait_sig(o2, 1'b1, c);
            rd_w(o2 ? tpc_pkg::ADDR_REG_B_LO : tpc_pkg::ADDR_REG_A_LO, v2);
         end
      join
      cmp16(v2 - v1, 16'(exp));
   endtask
   // Counts requests over one primary pulse; A never acts as compare here
   task automatic cap_count(input logic [7:0] prm, input int w, input int eb);
      int na, nb;
      na = 0;
      nb = 0;
      cap_setup(prm, 8'h07);
      fork
         begin
            @(negedge clk_i);
            tpc_pulse_src_inst.pulse(1'b0, w, 60);
         end
         repeat (150) begin
            @(posedge clk_i);
            #1;
            na += int'(irq_a === 1'b1);
            nb += int'(irq_b === 1'b1);
         end
      join
      cmp16(16'(na), 16'h0000);
      cmp16(16'(nb), 16'(eb));
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      reset_i = 1'b0;
      cmp8(dir, tpc_pkg::PORT_DIR_RST);
      cmp8(oe, 8'h00);
      rd_b(tpc_pkg::ADDR_PORT_DIR, d);
      cmp8(d, 8'hFF);
      wr_b(tpc_pkg::ADDR_PORT_DIR, 8'h5A);
      rd_b(tpc_pkg::ADDR_PORT_DIR, d);
      cmp8(d, 8'h5A);
      cmp8(oe, 8'hA5);
      wr_bit(3'h0, 1'b1);
      wr_bit(3'h6, 1'b0);
      rd_b(tpc_pkg::ADDR_PORT_DIR, d);
      cmp8(d, 8'h1B);
      wr_b(tpc_pkg::ADDR_PORT_DIR, 8'hFD);
      wr_b(tpc_pkg::ADDR_PORT_LATCH, 8'h00);
      wr_b(tpc_pkg::ADDR_REG_A_LO, 8'h03);
      for (int s = 0; s < 3; s++) begin
         wr_b(tpc_pkg::ADDR_MODE_CTRL, 8'h00);
         wr_b(tpc_pkg::ADDR_PRESCALER, 8'(s));
         wr_b(tpc_pkg::ADDR_MODE_CTRL, 8'h0C);
         wait_sig(0, 1'b1, n);
         wait_sig(0, 1'b1, n);
         cmp16(16'(n), 16'(4 * (s == 0 ? DB : (s == 1 ? DH : DF))));
      end
      wr_b(tpc_pkg::ADDR_MODE_CTRL, 8'h00);
      wr_b(tpc_pkg::ADDR_PRESCALER, 8'h00);
      wr_b(tpc_pkg::ADDR_REG_A_LO, 8'h05);
      wr_b(tpc_pkg::ADDR_REG_B_LO, 8'h01);
      wr_b(tpc_pkg::ADDR_OUT_CTRL, 8'h13);
      wr_b(tpc_pkg::ADDR_MODE_CTRL, 8'h0C);
      wait_sig(2, 1'b1, n);
      wait_sig(2, 1'b0, hi);
      wait_sig(2, 1'b1, lo);
      cmp16(16'(hi + lo), 16'(6 * DB));
      cmp16(16'(lo), 16'(2 * DB));
      wr_b(tpc_pkg::ADDR_OUT_CTRL, 8'h00);
      wr_b(tpc_pkg::ADDR_PORT_DIR, 8'hFF);
      cap_pair(8'h10, 8'h04, 1'b0, 1'b1, 1'b1, 50);
      cap_pair(8'h00, 8'h04, 1'b0, 1'b1, 1'b1, 50);
      cap_pair(8'h30, 8'h04, 1'b0, 1'b1, 1'b1, 20);
      cap_pair(8'h10, 8'h07, 1'b0, 1'b1, 1'b0, 20);
      cap_pair(8'h40, 8'h05, 1'b1, 1'b0, 1'b0, 50);
      cap_pair(8'hC0, 8'h05, 1'b1, 1'b0, 1'b0, 20);
      cap_count(8'h10, 1, 0);
      cap_count(8'h20, 40, 0);
      cap_count(8'h30, 40, 2);
      // Count clock from primary rising edges
      cap_setup(8'h13, 8'h00);
      repeat (3) tpc_pulse_src_inst.pulse(1'b0, 10, 10);
      rd_b(tpc_pkg::ADDR_CNT_LO, d);
      cmp8(d, 8'h03);
      end_sim();
   end
endmodule // test_timer16_interval_ppg_capture
